// file: core/codec_clock_gen_link_start.sv
// Clock source selection, doubling, division and AC-link start-up.
// Assumes all pins sampled synchronously on clk; derived clocks leave
// as one-cycle ticks, the bit clock as a pin level.
//
// Operation
// - Link stays stopped until warm reset
// - Warm start uses first input, no PLL; code forces this only while the clock register holds its reset value
// - Wait 162.4 ns before bit clock toggles
// - Powerdown drives link pins low quickly
// - Doubler per master input before selection
// - Bit 0 selects master input
// - Bits 2 and 1 enable doublers
// - Bit 7 picks PLL or external reference
// - Two divider sets, reference picks one
// - Hi-fi divider: field plus one
// - Voice divider: field plus one
// - PLL dividers written through paged nibbles
// - Core clock halved to make bit clock
// - Voice clock rates for sample rates
// - Aux converter clock from bit clock
// - Aux divisor table 16 down to 1
// - Settings changeable while running
`timescale 1ns/1ps
`default_nettype none
`include "clock_gen_regs.svh"

module codec_clock_gen_link_start (
    input  wire logic                    clk,
    input  wire logic                    resetn,
    input  wire logic                    masterClockInFirst,
    input  wire logic                    masterClockInSecond,
    input  wire logic                    pllClockIn,
    input  wire logic                    syncIn,
    input  wire logic                    slot2End,
    input  wire logic                    sdataInSource,
    input  wire clock_gen_pkg::regReq_t  regReq,
    output logic [15:0]                  regRdata,
    output logic                         bitClock,
    output logic                         sdataIn,
    output logic                         pllPowerUp,
    output logic [21:0]                  pllFraction,
    output logic [8:0]                   pllConfig,
    output clock_gen_pkg::clkTicks_t     ticks
);
    import clock_gen_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Helpers

    // Aux converter divisor code to terminal count
    function automatic logic [3:0] auxLimit(input logic [2:0] code);
        logic [3:0] lim;
        lim = 4'h0;
        unique case (code)
            3'h0: lim = 4'hF;
            3'h1: lim = 4'hB;
            3'h2: lim = 4'h7;
            3'h3: lim = 4'h5;
            3'h4: lim = 4'h3;
            3'h5: lim = 4'h2;
            3'h6: lim = 4'h1;
            3'h7: lim = 4'h0;
        endcase
        return lim;
    endfunction

    // Edge detect, both edges when doubled
    function automatic logic edgeTick(input logic now, input logic prev,
                                      input logic both);
        return both ? (now ^ prev) : (now & ~prev);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Registers

    logic [15:0] clockCtrl_q;
    logic        linkPowerdown_q;
    logic        internalClockDisable_q;
    logic        pllDisable_q;
    logic [8:0]  pllCfg_q;
    logic [2:0]  pageAddr_q;
    logic [3:0]  pageMem_q [8];
    logic        bootForce_q;
    linkState_t  state_q;
    logic [4:0]  startCnt_q;
    logic        syncPrev_q;
    logic        firstPrev_q;
    logic        secondPrev_q;
    logic        pllPrev_q;
    logic        useSecond_q;
    logic        useExt_q;
    logic        bitClock_q;
    logic        pdownPending_q;
    logic [2:0]  hifiCnt_q;
    logic [2:0]  hifiLim_q;
    logic [3:0]  voiceCnt_q;
    logic [3:0]  voiceLim_q;
    logic [3:0]  auxCnt_q;
    logic [3:0]  auxLim_q;
    logic [15:0] rdata_q;
    logic        hifiTick_q;
    logic        voiceTick_q;
    logic        auxTick_q;

    // Write decode
    wire wrPower = regReq.write && regReq.addr == `ADDR_POWERDOWN;
    wire wrPll   = regReq.write && regReq.addr == `ADDR_PLL_POWER;
    wire wrClock = regReq.write && regReq.addr == `ADDR_CLOCK_CTRL;
    wire wrPage  = regReq.write && regReq.addr == `ADDR_PLL_CTRL;
    wire [2:0] wrPageAddr = regReq.data[`PAGE_ADDR_MSB:`PAGE_ADDR_LSB];

    // Warm reset seen: SYNC falls while link stopped
    wire syncFall  = syncPrev_q & ~syncIn;
    wire linkIdle  = state_q == LINK_STOPPED;
    wire warmStart = linkIdle && syncFall;
    wire startDone = startCnt_q == 5'(`RST2CLK_CYCLES - 1);

    // Requested source, forced to first input and external at start-up
    // Boot reference forced
    wire reqSecond = clockCtrl_q[`CLK_SEL_BIT] & ~bootForce_q;
    wire reqExt    = clockCtrl_q[`CLK_REF_BIT] | bootForce_q;

    wire firstTick  = edgeTick(masterClockInFirst, firstPrev_q,
                               clockCtrl_q[`DBL_FIRST_BIT]);
    wire secondTick = edgeTick(masterClockInSecond, secondPrev_q,
                               clockCtrl_q[`DBL_SECOND_BIT]);
    wire pllTick    = pllClockIn & ~pllPrev_q;

    wire extTick  = useSecond_q ? secondTick : firstTick;
    wire coreTick = useExt_q ? extTick : pllTick;

    wire [6:0] pllDiv = {pageMem_q[7][2:0], pageMem_q[6]};
    wire [2:0] hifiField = useExt_q ?
        clockCtrl_q[`HIFI_DIV_MSB:`HIFI_DIV_LSB] : pllDiv[6:4];
    wire [3:0] voiceField = useExt_q ?
        clockCtrl_q[`VOICE_DIV_MSB:`VOICE_DIV_LSB] : pllDiv[3:0];

    // Link running and bit clock rising edge
    wire running = state_q == LINK_RUNNING;
    wire bitRise = running && coreTick && !bitClock_q && !pdownPending_q;

    // Read data selection
    wire [15:0] powerRead = (16'(linkPowerdown_q) << `LINK_PDOWN_BIT)
        | (16'(internalClockDisable_q) << `INT_CLK_DIS_BIT)
        | (16'(running) << `LINK_RUN_BIT)
        | (16'(!useExt_q) << `PLL_ACTIVE_BIT);
    wire [15:0] pageRead = {pllCfg_q, pageAddr_q, pageMem_q[pageAddr_q]};
    wire [15:0] readMux =
        regReq.addr == `ADDR_POWERDOWN  ? powerRead :
        regReq.addr == `ADDR_PLL_POWER  ?
            16'(pllDisable_q) << `PLL_DIS_BIT :
        regReq.addr == `ADDR_CLOCK_CTRL ? clockCtrl_q :
        regReq.addr == `ADDR_PLL_CTRL   ? pageRead : 16'h0000;

    ////////////////////////////////////////////////////////////////////
    // Control registers

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            clockCtrl_q <= `CLOCK_CTRL_RESET;
        end else if (wrClock) begin
            clockCtrl_q <= regReq.data;
        end
    end

    // Powerdown bits; warm reset clears link powerdown
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            linkPowerdown_q        <= 1'b0;
            internalClockDisable_q <= 1'b1;
        end else if (wrPower) begin
            linkPowerdown_q        <= regReq.data[`LINK_PDOWN_BIT];
            internalClockDisable_q <= regReq.data[`INT_CLK_DIS_BIT];
        end else if (warmStart) begin
            linkPowerdown_q <= 1'b0;
        end
    end

    // PLL runs only with both disables clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pllDisable_q <= 1'b1;
        end else if (wrPll) begin
            pllDisable_q <= regReq.data[`PLL_DIS_BIT];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pllCfg_q   <= 9'h000;
            pageAddr_q <= 3'h0;
            pageMem_q  <= '{default: 4'h0};
        end else if (wrPage) begin
            pllCfg_q   <= regReq.data[`PLL_CFG_MSB:`PLL_CFG_LSB];
            pageAddr_q <= wrPageAddr;
            pageMem_q[wrPageAddr] <= regReq.data[`PAGE_DATA_MSB:0];
        end
    end

    // Start-up force lasts until software writes the clock register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bootForce_q <= 1'b1;
        end else if (wrClock) begin
            bootForce_q <= 1'b0;
        end else if (warmStart) begin
            bootForce_q <= clockCtrl_q == `CLOCK_CTRL_RESET;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Link start-up and powerdown

    // Sampled inputs for edge detection
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            syncPrev_q   <= 1'b0;
            firstPrev_q  <= 1'b0;
            secondPrev_q <= 1'b0;
            pllPrev_q    <= 1'b0;
        end else begin
            syncPrev_q   <= syncIn;
            firstPrev_q  <= masterClockInFirst;
            secondPrev_q <= masterClockInSecond;
            pllPrev_q    <= pllClockIn;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q    <= LINK_STOPPED;
            startCnt_q <= 5'h00;
        end else begin
            unique case (state_q)
                LINK_STOPPED: begin
                    startCnt_q <= 5'h00;
                    if (warmStart) begin
                        state_q <= LINK_WAIT_START;
                    end
                end
                LINK_WAIT_START: begin
                    startCnt_q <= startCnt_q + 5'h01;
                    if (startDone) begin
                        state_q <= LINK_RUNNING;
                    end
                end
                LINK_RUNNING: begin
                    if (pdownPending_q && slot2End) begin
                        state_q <= LINK_STOPPED;
                    end
                end
            endcase
        end
    end

    // Powerdown request waits for end of slot 2
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pdownPending_q <= 1'b0;
        end else begin
            pdownPending_q <= running && linkPowerdown_q;
        end
    end

    // Bit clock is core clock halved
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bitClock_q <= 1'b0;
        end else if (!running) begin
            bitClock_q <= 1'b0;
        end else if (coreTick) begin
            bitClock_q <= ~bitClock_q & ~pdownPending_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Source switching and dividers

    // Source changes on a tick or while stopped
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            useSecond_q <= 1'b0;
            useExt_q    <= 1'b1;
        end else if (coreTick || linkIdle) begin
            useSecond_q <= reqSecond;
            useExt_q    <= reqExt;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hifiCnt_q  <= 3'h0;
            hifiLim_q  <= 3'h0;
            hifiTick_q <= 1'b0;
        end else begin
            hifiTick_q <= coreTick && hifiCnt_q >= hifiLim_q;
            if (coreTick) begin
                if (hifiCnt_q >= hifiLim_q) begin
                    hifiCnt_q <= 3'h0;
                    hifiLim_q <= hifiField;
                end else begin
                    hifiCnt_q <= hifiCnt_q + 3'h1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            voiceCnt_q  <= 4'h0;
            voiceLim_q  <= 4'h0;
            voiceTick_q <= 1'b0;
        end else begin
            voiceTick_q <= coreTick && voiceCnt_q >= voiceLim_q;
            if (coreTick) begin
                if (voiceCnt_q >= voiceLim_q) begin
                    voiceCnt_q <= 4'h0;
                    voiceLim_q <= voiceField;
                end else begin
                    voiceCnt_q <= voiceCnt_q + 4'h1;
                end
            end
        end
    end

    // Aux clock from bit clock; divisor table
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            auxCnt_q  <= 4'h0;
            auxLim_q  <= 4'hF;
            auxTick_q <= 1'b0;
        end else begin
            auxTick_q <= bitRise && auxCnt_q >= auxLim_q;
            if (bitRise) begin
                if (auxCnt_q >= auxLim_q) begin
                    auxCnt_q <= 4'h0;
                    auxLim_q <= auxLimit(
                        clockCtrl_q[`AUX_DIV_MSB:`AUX_DIV_LSB]);
                end else begin
                    auxCnt_q <= auxCnt_q + 4'h1;
                end
            end
        end
    end

    // Read data captured on read strobe
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= 16'h0000;
        end else if (regReq.read) begin
            rdata_q <= readMux;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs

    // Data pin held low when link not running
    assign sdataIn     = running & ~pdownPending_q & sdataInSource;
    assign bitClock    = bitClock_q;
    assign regRdata    = rdata_q;
    assign pllPowerUp  = ~pllDisable_q & ~internalClockDisable_q;
    assign pllConfig   = pllCfg_q;
    assign pllFraction = {pageMem_q[5][1:0], pageMem_q[4], pageMem_q[3],
                          pageMem_q[2], pageMem_q[1], pageMem_q[0]};
    assign ticks.core  = coreTick;
    assign ticks.hifi  = hifiTick_q;
    assign ticks.voice = voiceTick_q;
    assign ticks.aux   = auxTick_q;

endmodule

`default_nettype wire

// file: core/clock_gen_regs.svh
// Register offsets, field positions, reset values and timing counts
// for the codec clock generator and link start-up logic.
// Assumes a 100 MHz system clock.
`ifndef CLOCK_GEN_REGS_SVH
`define CLOCK_GEN_REGS_SVH

// Register offsets on the link control channel
`define ADDR_POWERDOWN    7'h26
`define ADDR_PLL_POWER    7'h3C
`define ADDR_CLOCK_CTRL   7'h44
`define ADDR_PLL_CTRL     7'h46

// Clock control register fields
`define CLK_SEL_BIT       0
`define DBL_FIRST_BIT     1
`define DBL_SECOND_BIT    2
`define AUX_DIV_LSB       3
`define AUX_DIV_MSB       5
`define CLK_REF_BIT       7
`define VOICE_DIV_LSB     8
`define VOICE_DIV_MSB     11
`define HIFI_DIV_LSB      12
`define HIFI_DIV_MSB      14
`define CLOCK_CTRL_RESET  16'h0080

// Powerdown register fields
`define LINK_RUN_BIT      0
`define PLL_ACTIVE_BIT    1
`define LINK_PDOWN_BIT    12
`define INT_CLK_DIS_BIT   13
`define PLL_DIS_BIT       9

// PLL control register fields
`define PLL_CFG_LSB       7
`define PLL_CFG_MSB       15
`define PAGE_ADDR_LSB     4
`define PAGE_ADDR_MSB     6
`define PAGE_DATA_MSB     3

// Warm-reset release to bit clock start, least time
`define T_RST2CLK_PS      162400
`define CLK_PERIOD_PS     10000
`define RST2CLK_CYCLES    ((`T_RST2CLK_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

// file: core/clock_gen_pkg.sv
// Types shared by the codec clock generator and its surroundings.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package clock_gen_pkg;

    // Register write or read request from the link frame decoder
    typedef struct packed {
        logic        write;
        logic        read;
        logic [6:0]  addr;
        logic [15:0] data;
    } regReq_t;

    // One-cycle clock-enable ticks of the core, hi-fi, voice and aux clocks
    typedef struct packed {
        logic core;
        logic hifi;
        logic voice;
        logic aux;
    } clkTicks_t;

    // Link start-up and powerdown states
    typedef enum logic [1:0] {
        LINK_STOPPED,
        LINK_WAIT_START,
        LINK_RUNNING
    } linkState_t;

endpackage

`default_nettype wire

// file: verification/codec_clock_gen_link_start_asserts.sv
// Checker for clock generation and link start-up.
// Assumes bind onto the top module ports.
`timescale 1ns/1ps
`default_nettype none
`include "clock_gen_regs.svh"
module codec_clock_gen_link_start_asserts (
    input wire logic                   clk,
    input wire logic                   resetn,
    input wire logic                   syncIn,
    input wire logic                   slot2End,
    input wire clock_gen_pkg::regReq_t regReq,
    input wire logic [15:0]            regRdata,
    input wire logic                   bitClock,
    input wire logic                   sdataIn,
    input wire logic                   pllPowerUp,
    input wire logic [8:0]             pllConfig,
    input wire clock_gen_pkg::clkTicks_t ticks
);
    import clock_gen_pkg::*;
    logic        warmSeen_q;
    logic        pdHold_q;
    wire  [15:0] wdat = regReq.data;
    wire  [8:0]  cfgIn = regReq.data[15:7];
    wire         wr26 = regReq.write && regReq.addr == `ADDR_POWERDOWN;
    wire         wr3C = regReq.write && regReq.addr == `ADDR_PLL_POWER;
    wire         wr46 = regReq.write && regReq.addr == `ADDR_PLL_CTRL;
    wire         wr44 = regReq.write && regReq.addr == `ADDR_CLOCK_CTRL;
    wire         rd44 = regReq.read && regReq.addr == `ADDR_CLOCK_CTRL;
    ////////////////////////////////////////////////////////////
    // Warm start seen and powerdown pending
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            warmSeen_q <= 1'b0;
            pdHold_q   <= 1'b0;
        end else begin
            warmSeen_q <= warmSeen_q | $fell(syncIn);
            pdHold_q   <= wr26 ? wdat[12] : pdHold_q & ~$fell(syncIn);
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence wrThenRd;
        wr44 ##1 !regReq.write ##1 rd44;
    endsequence
    AST_LINK_HELD: assert property (!warmSeen_q |-> !bitClock && !sdataIn)
        else $error("link pins moved before warm reset");
    AST_START_WAIT: assert property ($fell(syncIn) && !warmSeen_q
        |=> !bitClock [*8] ##1 !bitClock [*8])
        else $error("bit clock started too early");
    AST_PD_LOW: assert property (pdHold_q && $past(pdHold_q, 3)
        |-> !$rose(bitClock) && !sdataIn)
        else $error("link pins not low in powerdown");
    AST_PD_STOP: assert property (slot2End && $past(pdHold_q, 3)
        && pdHold_q |=> ##1 !bitClock [*8])
        else $error("bit clock not stopped after slot 2");
    AST_RISE_ON_CORE: assert property ($rose(bitClock) |-> $past(ticks.core))
        else $error("bit clock rose without core tick");
    AST_HIFI_ON_CORE: assert property (ticks.hifi |-> $past(ticks.core))
        else $error("hifi tick without core tick");
    AST_VOICE_ON_CORE: assert property (ticks.voice |-> $past(ticks.core))
        else $error("voice tick without core tick");
    AST_AUX_ON_CORE: assert property (ticks.aux |-> $past(ticks.core))
        else $error("aux tick without core tick");
    AST_READ_BACK: assert property (wrThenRd |=> regRdata == $past(wdat, 3))
        else $error("clock control read back wrong");
    AST_PLL_OFF: assert property (wr3C && wdat[9] |=> !pllPowerUp)
        else $error("pll powered while disabled");
    AST_PAGE_CFG: assert property (wr46 |=> pllConfig == $past(cfgIn))
        else $error("pll config not stored");
    // Main scenarios reached
    COV_START: cover property ($fell(syncIn) ##[1:40] $rose(bitClock));
    COV_PDOWN: cover property (pdHold_q ##1 $fell(syncIn));
    COV_READ: cover property (wrThenRd);
endmodule
bind codec_clock_gen_link_start codec_clock_gen_link_start_asserts chk (
    .clk(clk), .resetn(resetn), .syncIn(syncIn), .slot2End(slot2End),
    .regReq(regReq),
    .regRdata(regRdata), .bitClock(bitClock), .sdataIn(sdataIn),
    .pllPowerUp(pllPowerUp), .pllConfig(pllConfig), .ticks(ticks));
`default_nettype wire

// file: verification/ac_link_ctrl_model.sv
// Link controller model: warm reset pulses and slot 2 ends.
// Assumes the bench raises warmGo for one cycle per warm reset.
`timescale 1ns/1ps
`default_nettype none
module ac_link_ctrl_model (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic warmGo,
    output logic      syncIn,
    output logic      slot2End
);
    logic [7:0] syncCnt_q;
    logic [5:0] slotCnt_q;
    // SYNC low in reset, 1.3 us pulse
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            syncCnt_q <= 8'h00;
        end else if (warmGo) begin
            syncCnt_q <= 8'h82;
        end else if (syncCnt_q != 8'h00) begin
            syncCnt_q <= syncCnt_q - 8'h01;
        end
    end
    assign syncIn = syncCnt_q != 8'h00;
    // Slot 2 end once per 64 cycles
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            slotCnt_q <= 6'h00;
        end else begin
            slotCnt_q <= slotCnt_q + 6'h01;
        end
    end
    assign slot2End = slotCnt_q == 6'h3F;
endmodule
`default_nettype wire

// file: verification/test_codec_clock_gen_link_start.sv
// Bench: register calls, warm and cold resets, tick spacing.
// Assumes the checker bind and controller model are compiled.
`timescale 1ns/1ps
`default_nettype none
`include "clock_gen_regs.svh"
module test_codec_clock_gen_link_start;
    import clock_gen_pkg::*;
    logic        clk, resetn, pllIn, dataSrc, warmGo;
    logic        syncIn, slot2End, bitClock, sdataIn, pllPowerUp;
    logic [1:0]  phA;
    logic [2:0]  phB;
    logic [15:0] regRdata;
    logic [21:0] pllFraction;
    logic [8:0]  pllConfig;
    logic [3:0]  tv;
    regReq_t     regReq;
    clkTicks_t   ticks;
    int          bad_count, checks_done, cycles, n, gap;
    int          auxDiv [8] = '{16, 12, 8, 6, 4, 3, 2, 1};
    logic [2:0]  selTab [4] = '{3'h0, 3'h2, 3'h1, 3'h5};
    int          coreTab [4] = '{4, 2, 6, 3};
    wire         firstIn = phA[1];
    wire         secondIn = phB < 3'h3;
    assign tv = ticks;
    codec_clock_gen_link_start dut (
        .clk(clk), .resetn(resetn), .masterClockInFirst(firstIn),
        .masterClockInSecond(secondIn), .pllClockIn(pllIn),
        .syncIn(syncIn), .slot2End(slot2End), .sdataInSource(dataSrc),
        .regReq(regReq), .regRdata(regRdata), .bitClock(bitClock),
        .sdataIn(sdataIn), .pllPowerUp(pllPowerUp),
        .pllFraction(pllFraction), .pllConfig(pllConfig), .ticks(ticks));
    ac_link_ctrl_model ctl (.clk(clk), .resetn(resetn), .warmGo(warmGo),
        .syncIn(syncIn), .slot2End(slot2End));
    ////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        phA <= phA + 2'h1;
        phB <= (phB == 3'h5) ? 3'h0 : phB + 3'h1;
        pllIn <= ~pllIn;
        dataSrc <= ~dataSrc;
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            bad_count++;
            close_out();
        end
    end
    task automatic close_out();
        if (bad_count == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s exp %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge clk);
        regReq <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        regReq <= '0;
        @(negedge clk);
    endtask
    task automatic rdChk(input string what, input logic [6:0] a,
                         input logic [15:0] exp);
        @(posedge clk);
        regReq <= '{1'b0, 1'b1, a, 16'h0000};
        @(posedge clk);
        regReq <= '0;
        @(negedge clk);
        check(what, regRdata, exp);
    endtask
    // Cycles between pulses of one tick, second full gap
    task automatic gapOf(input int k, output int g);
        for (int r = 0; r < 3; r++) begin
            g = 0;
            do begin
                @(negedge clk);
                g++;
            end while (tv[k] !== 1'b1 && g < 400);
        end
    endtask
    // Count link pin activity over c cycles
    task automatic quiet(input int c, output int q);
        q = 0;
        repeat (c) begin
            @(negedge clk);
            q += (bitClock !== 1'b0) + (sdataIn !== 1'b0);
        end
    endtask
    // Warm pulse, then cycles from SYNC fall to bit clock
    task automatic warm();
        @(posedge clk);
        warmGo <= 1'b1;
        @(posedge clk);
        warmGo <= 1'b0;
        do @(negedge clk); while (syncIn !== 1'b0);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (bitClock !== 1'b1 && n < 100);
        check("start", n >= 17 && n <= 26, 1);
        check("data", sdataIn, dataSrc);
    endtask
    initial begin
        resetn = 1'b0;
        warmGo = 1'b0;
        regReq = '0;
        phA = 2'h0;
        phB = 3'h0;
        pllIn = 1'b0;
        dataSrc = 1'b0;
        cycles = 0;
        bad_count = 0;
        checks_done = 0;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        rdChk("ctl", `ADDR_CLOCK_CTRL, 16'h0080);
        rdChk("pd", `ADDR_POWERDOWN, 16'h2000);
        rdChk("pllpd", `ADDR_PLL_POWER, 16'h0200);
        wr(7'h10, 16'hFFFF);
        rdChk("unmapped", 7'h10, 16'h0000);
        wr(`ADDR_PLL_CTRL, 16'hA183);
        quiet(200, n);
        check("held", n, 0);
        warm();
        gapOf(3, gap);
        check("first ref", gap, 4);
        rdChk("kept", `ADDR_PLL_CTRL, 16'hA183);
        check("cfg", pllConfig, 9'h143);
        // Every hi-fi and aux divider code, eight of the voice codes, in external mode
        for (int i = 0; i < 8; i++) begin
            wr(`ADDR_CLOCK_CTRL, {1'b0, i[2:0], i[2:0], i[0], 2'h2,
                                  i[2:0], 3'h0});
            gapOf(2, gap);
            check("hifi", gap, (i + 1) * 4);
            gapOf(1, gap);
            check("voice", gap, ({i[2:0], i[0]} + 1) * 4);
            gapOf(0, gap);
            check("aux", gap, auxDiv[i] * 8);
        end
        for (int j = 0; j < 4; j++) begin
            wr(`ADDR_CLOCK_CTRL, {13'h0010, selTab[j]});
            gapOf(3, gap);
            check("core", gap, coreTab[j]);
        end
        wr(`ADDR_POWERDOWN, 16'h0000);
        wr(`ADDR_PLL_POWER, 16'h0000);
        check("pll on", pllPowerUp, 1);
        wr(`ADDR_PLL_CTRL, 16'h0072);
        wr(`ADDR_PLL_CTRL, 16'h0063);
        wr(`ADDR_PLL_CTRL, 16'h0015);
        check("frac", pllFraction, 22'h000053);
        wr(`ADDR_CLOCK_CTRL, 16'h0000);
        rdChk("pll sel", `ADDR_CLOCK_CTRL, 16'h0000);
        gapOf(3, gap);
        check("pll core", gap, 2);
        gapOf(2, gap);
        check("pll hifi", gap, 6);
        gapOf(1, gap);
        check("pll voice", gap, 8);
        rdChk("pll use", `ADDR_POWERDOWN, 16'h0003);
        wr(`ADDR_CLOCK_CTRL, 16'h0080);
        wr(`ADDR_PLL_POWER, 16'h0200);
        check("pll off", pllPowerUp, 0);
        wr(`ADDR_POWERDOWN, 16'h1000);
        repeat (5) @(negedge clk);
        quiet(300, n);
        check("pdown", n, 0);
        warm();
        rdChk("restart", `ADDR_POWERDOWN, 16'h0001);
        @(posedge clk);
        resetn <= 1'b0;
        repeat (100) @(posedge clk);
        resetn <= 1'b1;
        rdChk("cold", `ADDR_CLOCK_CTRL, 16'h0080);
        rdChk("cold pd", `ADDR_POWERDOWN, 16'h2000);
        check("cold frac", pllFraction, 22'h000000);
        quiet(200, n);
        check("cold held", n, 0);
        close_out();
    end
endmodule
`default_nettype wire
